/* rib_map.svh */
// offsets, field positions, reset values and counts of the reset-init register bank
// assumes: included by the design modules and the bench, not by rib_pkg.sv; definitions only
`ifndef RIB_MAP_SVH
`define RIB_MAP_SVH

// ----------------------------------------
// sizes
// ----------------------------------------
`define RIB_NREG 33
`define RIB_PC_W 21
`define RIB_STACK_DEPTH 31

// ----------------------------------------
// apb byte offsets (table registers sit at index * 4 from 12'h000)
// ----------------------------------------
`define RIB_OFS_CORE_CTL 12'h090
`define RIB_OFS_STACK_PTR 12'h094
`define RIB_OFS_TOS_UPPER 12'h098
`define RIB_OFS_TOS_HIGH 12'h09c
`define RIB_OFS_TOS_LOW 12'h0a0
`define RIB_OFS_PORT_A 12'h0a4

// ----------------------------------------
// fields
// ----------------------------------------
`define RIB_CORE_EN_HI 7
`define RIB_CORE_EN_LO 6
`define RIB_PA_FREE_HI 7
`define RIB_PA_FREE_LO 6

// ----------------------------------------
// reset values and vectors
// ----------------------------------------
`define RIB_RST_ZERO 8'h00
`define RIB_RST_ONES 8'hff
`define RIB_RST_CMP 8'h07
`define RIB_RST_TXS 8'h02
`define RIB_RST_PRIO3 8'h07
`define RIB_RST_PRIO2 8'h3f
`define RIB_VEC_HI 21'h000008
`define RIB_VEC_LO 21'h000018

`endif

/* rib_pkg.sv */
// types of the reset-init register bank
// assumes: rib_map.svh alongside
package rib_pkg;

	// ----------------------------------------
	// register indices, byte address = index * 4
	// ----------------------------------------
	typedef enum logic [5:0] {
		capture1_value_high, capture1_value_low, capture1_control,
		capture2_value_high, capture2_value_low, capture2_control,
		capture3_value_high, capture3_value_low, capture3_control,
		comparator_reference_control, comparator_control,
		timer_three_count_high, timer_three_count_low, timer_three_control,
		parallel_slave_control, serial1_rate_divisor, serial1_receive_buffer,
		serial1_transmit_buffer, serial1_transmit_status, serial1_receive_status,
		irq_priority_three, irq_flags_three, irq_enables_three,
		irq_priority_two, irq_flags_two, irq_enables_two,
		irq_priority_one, irq_flags_one, irq_enables_one,
		external_bus_control, oscillator_trim, port_j_direction, port_h_direction
	} rib_reg_t;

	// per-register init behaviour; a set keep bit retains the old value
	typedef struct packed {
		logic [7:0] impl;
		logic [7:0] por_val;
		logic [7:0] por_keep;
		logic [7:0] warm_val;
		logic [7:0] warm_keep;
	} rib_init_t;

	// reset and wake-up events, one-cycle pulses on the core clock
	typedef struct packed {
		logic por;
		logic warm;
		logic wake_wdt;
		logic wake_irq;
	} rib_rst_evt_t;

endpackage

/* rib_wake.sv */
// program counter vectoring and hardware stack push on interrupt wake-up
// assumes: all inputs come from logic on i_clk; i_clr is a one-cycle reset-class pulse
`timescale 1ns/1ps
`include "rib_map.svh"
module rib_wake import rib_pkg::*; #(
	parameter int DEPTH = `RIB_STACK_DEPTH,
	parameter int PW = `RIB_PC_W
) (
	input wire logic i_clk, // core clock
	input wire logic i_rst_n, // synchronised reset, low
	input wire logic i_clr, // por or warm reset pulse
	input wire logic i_wake_irq, // interrupt wake-up pulse
	input wire logic i_hi_prio, // wake source is high priority
	input wire logic i_en_hi, // high global enable
	input wire logic i_en_lo, // low global enable
	input wire logic [PW-1:0] i_pc, // current program counter
	output logic o_pc_load, // one-cycle vector load
	output logic [PW-1:0] o_pc_vector, // vector to load
	output logic [4:0] o_ptr, // stack pointer
	output logic [PW-1:0] o_tos // top of stack
);

	logic [PW-1:0] stack_r [0:DEPTH-1];
	logic vec_ok;

	assign vec_ok = i_wake_irq & ~i_clr & ((i_hi_prio & i_en_hi) | (~i_hi_prio & i_en_lo));

	// ----------------------------------------
	// vector load
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pc_load <= 1'b0;
			o_pc_vector <= '0;
		end else begin
			o_pc_load <= vec_ok;
			if (vec_ok) begin
				o_pc_vector <= i_hi_prio ? PW'(`RIB_VEC_HI) : PW'(`RIB_VEC_LO);
			end
		end
	end

	// ----------------------------------------
	// stack push; a full stack drops the push rather than wrapping
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (vec_ok && o_ptr < 5'(DEPTH)) begin
			stack_r[o_ptr] <= i_pc;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ptr <= 5'h00;
			o_tos <= '0;
		end else if (i_clr) begin
			o_ptr <= 5'h00;
			o_tos <= '0;
		end else if (vec_ok && o_ptr < 5'(DEPTH)) begin
			o_ptr <= o_ptr + 5'h01;
			o_tos <= i_pc;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_vec_high: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		vec_ok && i_hi_prio |=> o_pc_load && o_pc_vector == PW'(`RIB_VEC_HI))
		else $error("high priority wake did not load vector 0008h");
	a_vec_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		vec_ok && !i_hi_prio |=> o_pc_load && o_pc_vector == PW'(`RIB_VEC_LO))
		else $error("low priority wake did not load vector 0018h");
	a_stack_push: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		vec_ok && o_ptr < 5'(DEPTH) |=> o_ptr == $past(o_ptr) + 5'h01 && o_tos == $past(i_pc))
		else $error("wake push did not store pc or advance pointer");
	c_wake_vector: cover property (@(posedge i_clk) disable iff (!i_rst_n) vec_ok ##1 o_pc_load);

endmodule

/* rib_top.sv */
// reset-init register bank: table registers, core interrupt control, stack view and port a
// assumes: apb master on i_ref_clk; reset/wake events and irq flag pulses from core logic on the same clock
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "rib_map.svh"
// Function
// - retained bits keep value; unknown bits free; unimplemented bits always read zero
// - interrupt wake-up leaves a flag set in the peripheral irq flag registers
// - enabled interrupt wake-up loads vector 0008h high or 0018h low
// - enabled interrupt wake-up pushes pc to top of stack, pointer advances; the push is dropped once 31 entries are full
// - comparator control resets to 0000 0111 on every reset, kept on wake
// - timer three high clears only on power-on/brown-out, kept otherwise
// - serial1 transmit buffer unknown at power-on, zero on warm reset, kept on wake
// - irq priority one resets to 1111 1111 on every reset, kept on wake
// - port j direction resets to 1111 1111 on every reset, kept on wake
// - port a bits 6 and 7 read zero unless oscillator mode frees them
module rib_top import rib_pkg::*; #(
	parameter int NREG = `RIB_NREG
) (
	input wire logic i_ref_clk, // core clock, 10 mhz
	input wire logic i_nrst, // async reset, active low
	input wire logic [11:0] i_paddr, // apb address
	input wire logic i_psel, // apb select
	input wire logic i_penable, // apb enable
	input wire logic i_pwrite, // apb direction
	input wire logic [31:0] i_pwdata, // apb write data
	output logic [31:0] o_prdata, // apb read data
	output logic o_pready, // apb ready
	output logic o_pslverr, // apb error, unmapped address
	input rib_rst_evt_t i_rst_evt, // reset class and wake pulses
	input wire logic [23:0] i_irq_evt, // flag set pulses, flags one/two/three
	input wire logic i_wake_hi_prio, // wake source is high priority
	input wire logic [`RIB_PC_W-1:0] i_pc, // current program counter
	input wire logic i_osc_frees_ra67, // oscillator mode frees port a 7:6
	input wire logic [7:0] i_port_a_pins, // port a pin levels, async
	output logic o_pc_load, // vector load pulse
	output logic [`RIB_PC_W-1:0] o_pc_vector, // interrupt vector
	output logic [4:0] o_stack_ptr, // hardware stack pointer
	output logic [7:0] o_port_j_dir, // port j direction, 1 = input
	output logic [7:0] o_cmp_ctl // comparator control
);

	// ----------------------------------------
	// init table
	// ----------------------------------------
	// field order: impl, por_val, por_keep, warm_val, warm_keep
	function automatic rib_init_t rib_init(input int idx);
		rib_init_t e;
		e = '{8'hff, `RIB_RST_ZERO, 8'h00, `RIB_RST_ZERO, 8'h00};
		case (idx)
			capture1_value_high, capture1_value_low, capture2_value_high, capture3_value_high:
				e = '{8'hff, `RIB_RST_ZERO, 8'hff, `RIB_RST_ZERO, 8'hff};
			capture2_value_low, capture3_value_low, timer_three_count_high,
			timer_three_count_low, timer_three_control:
				e = '{8'hff, `RIB_RST_ZERO, 8'h00, `RIB_RST_ZERO, 8'hff};
			capture1_control, capture2_control, capture3_control, irq_flags_two, irq_enables_two:
				e.impl = 8'h3f;
			comparator_control:
				e = '{8'hff, `RIB_RST_CMP, 8'h00, `RIB_RST_CMP, 8'h00};
			parallel_slave_control:
				e.impl = 8'h0f;
			serial1_transmit_buffer:
				e = '{8'hff, `RIB_RST_ZERO, 8'hff, `RIB_RST_ZERO, 8'h00};
			serial1_transmit_status:
				e = '{8'hff, `RIB_RST_TXS, 8'h00, `RIB_RST_TXS, 8'h00};
			serial1_receive_status:
				e = '{8'hff, `RIB_RST_ZERO, 8'h01, `RIB_RST_ZERO, 8'h01};
			irq_priority_three:
				e = '{8'h07, `RIB_RST_PRIO3, 8'h00, `RIB_RST_PRIO3, 8'h00};
			irq_flags_three, irq_enables_three:
				e.impl = 8'h07;
			irq_priority_two:
				e = '{8'h3f, `RIB_RST_PRIO2, 8'h00, `RIB_RST_PRIO2, 8'h00};
			irq_priority_one, port_j_direction, port_h_direction:
				e = '{8'hff, `RIB_RST_ONES, 8'h00, `RIB_RST_ONES, 8'h00};
			external_bus_control:
				e.impl = 8'hbc;
			oscillator_trim:
				e.impl = 8'hdf;
			default:
				e = e;
		endcase
		return e;
	endfunction

	// ----------------------------------------
	// reset release and pin sync
	// ----------------------------------------
	logic [1:0] rst_sync_r;
	logic rst_n;
	logic [7:0] pa_meta_r;
	logic [7:0] pa_sync_r;

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pa_meta_r <= 8'h00;
			pa_sync_r <= 8'h00;
		end else begin
			pa_meta_r <= i_port_a_pins;
			pa_sync_r <= pa_meta_r;
		end
	end

	// ----------------------------------------
	// reset class decode
	// ----------------------------------------
	logic por;
	logic warm;
	logic clr;

	assign por = i_rst_evt.por;
	assign warm = i_rst_evt.warm & ~i_rst_evt.por;
	assign clr = i_rst_evt.por | i_rst_evt.warm;

	// ----------------------------------------
	// apb decode; one wait state, answer registered
	// ----------------------------------------
	logic [5:0] idx;
	logic tbl_hit;
	logic hit;
	logic wr_acc;
	logic [7:0] rd_val;
	logic [7:0] regs_r [0:NREG-1];
	logic [7:0] core_ctl_r;
	logic [`RIB_PC_W-1:0] tos;
	logic [7:0] port_a_rd;

	assign idx = i_paddr[7:2];
	assign tbl_hit = (i_paddr[11:8] == 4'h0) && (i_paddr[1:0] == 2'b00) && (idx < 6'(NREG));
	assign wr_acc = i_psel & i_penable & o_pready & i_pwrite & hit & ~clr;
	assign port_a_rd = {i_osc_frees_ra67 ? pa_sync_r[7:6] : 2'b00, pa_sync_r[5:0]};

	always_comb begin
		hit = 1'b1;
		rd_val = 8'h00;
		if (tbl_hit) begin
			rd_val = regs_r[idx];
		end else begin
			unique case (i_paddr)
				`RIB_OFS_CORE_CTL: rd_val = core_ctl_r;
				`RIB_OFS_STACK_PTR: rd_val = {3'b000, o_stack_ptr};
				`RIB_OFS_TOS_UPPER: rd_val = {3'b000, tos[20:16]};
				`RIB_OFS_TOS_HIGH: rd_val = tos[15:8];
				`RIB_OFS_TOS_LOW: rd_val = tos[7:0];
				`RIB_OFS_PORT_A: rd_val = port_a_rd;
				default: hit = 1'b0;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0000_0000;
		end else begin
			o_pready <= i_psel & i_penable & ~o_pready;
			o_pslverr <= i_psel & i_penable & ~o_pready & ~hit;
			if (i_psel && i_penable && !o_pready) begin
				o_prdata <= (i_pwrite || !hit) ? 32'h0000_0000 : {24'h000000, rd_val};
			end
		end
	end

	// ----------------------------------------
	// table registers; reset class beats a write in the same cycle
	// ----------------------------------------
	generate
		for (genvar g = 0; g < NREG; g++) begin : g_reg
			localparam rib_init_t E = rib_init(g);
			logic [7:0] set_g;
			logic wr_g;

			assign set_g = (g == irq_flags_one) ? i_irq_evt[7:0] :
				(g == irq_flags_two) ? i_irq_evt[15:8] :
				(g == irq_flags_three) ? i_irq_evt[23:16] : 8'h00;
			assign wr_g = wr_acc && tbl_hit && (idx == 6'(g)) && (g != serial1_receive_buffer);

			always_ff @(posedge i_ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					regs_r[g] <= E.por_val & E.impl;
				end else if (por) begin
					regs_r[g] <= ((regs_r[g] & E.por_keep) | (E.por_val & ~E.por_keep)) & E.impl;
				end else if (warm) begin
					regs_r[g] <= ((regs_r[g] & E.warm_keep) | (E.warm_val & ~E.warm_keep)) & E.impl;
				end else if (wr_g) begin
					// a flag event in the clearing cycle survives the write
					regs_r[g] <= (i_pwdata[7:0] | set_g) & E.impl;
				end else begin
					regs_r[g] <= (regs_r[g] | set_g) & E.impl;
				end
			end

			a_unimpl_zero: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
				(regs_r[g] & ~E.impl) == 8'h00)
				else $error("unimplemented register bit is not zero");
		end
	endgenerate

	// ----------------------------------------
	// core interrupt control, wake vectoring, outputs
	// ----------------------------------------
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			core_ctl_r <= 8'h00;
		end else if (clr) begin
			core_ctl_r <= 8'h00;
		end else if (wr_acc && i_paddr == `RIB_OFS_CORE_CTL) begin
			core_ctl_r <= {i_pwdata[`RIB_CORE_EN_HI], i_pwdata[`RIB_CORE_EN_LO], 6'b000000};
		end
	end

	rib_wake #(
		.DEPTH(`RIB_STACK_DEPTH),
		.PW(`RIB_PC_W)
	) u_wake (
		.i_clk(i_ref_clk),
		.i_rst_n(rst_n),
		.i_clr(clr),
		.i_wake_irq(i_rst_evt.wake_irq),
		.i_hi_prio(i_wake_hi_prio),
		.i_en_hi(core_ctl_r[`RIB_CORE_EN_HI]),
		.i_en_lo(core_ctl_r[`RIB_CORE_EN_LO]),
		.i_pc(i_pc),
		.o_pc_load(o_pc_load),
		.o_pc_vector(o_pc_vector),
		.o_ptr(o_stack_ptr),
		.o_tos(tos)
	);

	// copies follow the registers one cycle later
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_port_j_dir <= `RIB_RST_ONES;
			o_cmp_ctl <= `RIB_RST_CMP;
		end else begin
			o_port_j_dir <= regs_r[port_j_direction];
			o_cmp_ctl <= regs_r[comparator_control];
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!rst_n);

	a_wake_flag: assert property (i_rst_evt.wake_irq && !clr && (i_irq_evt & 24'h3f3fff & 24'h07ffff) != 24'h0 |=>
		(regs_r[irq_flags_one] | regs_r[irq_flags_two] | regs_r[irq_flags_three]) != 8'h00)
		else $error("interrupt wake left no flag set");
	a_cmp_reset: assert property (clr |=> regs_r[comparator_control] == `RIB_RST_CMP ##1
		o_cmp_ctl == `RIB_RST_CMP)
		else $error("comparator control not 0000 0111 after reset");
	a_cmp_wake: assert property (i_rst_evt.wake_irq && !clr && !wr_acc |=>
		$stable(regs_r[comparator_control]))
		else $error("comparator control changed on wake-up");
	a_tmr_warm: assert property (warm |=> $stable(regs_r[timer_three_count_high]))
		else $error("timer three high changed on warm reset");
	a_tx_warm: assert property (warm |=> regs_r[serial1_transmit_buffer] == 8'h00)
		else $error("transmit buffer not cleared on warm reset");
	a_prio_reset: assert property (clr |=> regs_r[irq_priority_one] == `RIB_RST_ONES)
		else $error("priority one not all ones after reset");
	a_dir_j_reset: assert property (clr |=> ##1 o_port_j_dir == `RIB_RST_ONES)
		else $error("port j direction not all inputs after reset");
	a_port_a_gate: assert property (i_psel && i_penable && !o_pready && !i_pwrite &&
		i_paddr == `RIB_OFS_PORT_A && !i_osc_frees_ra67 |=> o_pready && o_prdata[7:6] == 2'b00)
		else $error("port a bits 7:6 visible while not freed");
	a_por_wins: assert property (por && i_rst_evt.warm |=>
		regs_r[timer_three_count_high] == 8'h00)
		else $error("power-on values not applied with mixed resets");
	a_ready_pulse: assert property (o_pready |=> !o_pready)
		else $error("ready held past one cycle");
	a_flag_set_wins: assert property (i_irq_evt[1] && !clr |=> regs_r[irq_flags_one][1])
		else $error("flag event lost against a write");

	c_por: cover property (por ##1 regs_r[irq_priority_one] == `RIB_RST_ONES);
	c_warm: cover property (warm ##1 regs_r[serial1_transmit_buffer] == 8'h00);
	c_write_read: cover property (wr_acc ##2 i_psel && !i_pwrite ##2 o_pready);

endmodule

/* rib_top_bench.sv */
// self-checking bench for the reset-init register bank top
// assumes: rib_pkg and rib_map.svh compiled first; bench is the only apb master
`timescale 1ns/1ps
`include "rib_map.svh"
module rib_top_bench import rib_pkg::*;;
	typedef struct packed {rib_reg_t r; logic [7:0] rv; logic [7:0] wd; logic [7:0] ex;} rib_row_t;
	typedef struct packed {rib_rst_evt_t e; logic [7:0] tmr; logic [7:0] cmp;} rib_cls_t;
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, hi_prio, osc_free, pc_load;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [23:0] irq_evt;
	logic [20:0] pc, pc_vec;
	logic [7:0] pins, jdir, cmpc;
	logic [4:0] sp;
	rib_rst_evt_t rst_evt;
	int fail_count = 0;
	int samples_checked = 0;
	int sp_exp = 0;
	rib_row_t rows [9];
	rib_cls_t cls [4];

	rib_top DUT (.i_ref_clk(clk), .i_nrst(nrst), .i_paddr(paddr), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_rst_evt(rst_evt), .i_irq_evt(irq_evt), .i_wake_hi_prio(hi_prio), .i_pc(pc),
		.i_osc_frees_ra67(osc_free), .i_port_a_pins(pins), .o_pc_load(pc_load), .o_pc_vector(pc_vec),
		.o_stack_ptr(sp), .o_port_j_dir(jdir), .o_cmp_ctl(cmpc));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [11:0] ra(input rib_reg_t r);
		return {4'h0, r, 2'b00};
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		samples_checked++;
		if (seen !== ex) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, ex, seen);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// holds the request until pready is seen at a rising edge
	task automatic apb(input logic [11:0] ad, input logic w, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= ad;
		pwrite <= w;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) fail_count++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] ad, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(ad, 1'b1, {24'h0, d}, r, e);
		chk("write error", {31'h0, e}, 32'h0);
	endtask

	task automatic rdc(input string nm, input logic [11:0] ad, input logic [7:0] ex);
		logic [31:0] r;
		logic e;
		apb(ad, 1'b0, 32'h0, r, e);
		chk(nm, r, {24'h0, ex});
	endtask

	task automatic pulse(input rib_rst_evt_t e);
		@(posedge clk);
		rst_evt <= e;
		@(posedge clk);
		rst_evt <= '0;
		if (e.por || e.warm) sp_exp = 0;
	endtask

	task automatic wake(input logic [7:0] ctl, input logic hi, input logic ld, input logic [20:0] vec);
		logic [20:0] wpc;
		logic push;
		wr(ra(irq_flags_one), 8'h00);
		wr(`RIB_OFS_CORE_CTL, ctl);
		wpc = pc + 21'h01235;
		push = ld && sp_exp < 31;
		@(posedge clk);
		rst_evt <= 4'h1;
		hi_prio <= hi;
		pc <= wpc;
		irq_evt <= 24'h000001;
		@(posedge clk);
		rst_evt <= '0;
		irq_evt <= '0;
		#1;
		if (push) sp_exp++;
		if (ld == 1'b0 || push) chk("vector load", {31'h0, pc_load}, {31'h0, ld});
		if (push) chk("vector", {11'h0, pc_vec}, {11'h0, vec});
		chk("stack pointer", {27'h0, sp}, 32'(sp_exp));
		@(posedge clk);
		#1;
		chk("load end", {31'h0, pc_load}, 32'h0);
		rdc("wake flag", ra(irq_flags_one), 8'h01);
		if (push) begin
			rdc("tos low", `RIB_OFS_TOS_LOW, wpc[7:0]);
			rdc("tos high", `RIB_OFS_TOS_HIGH, wpc[15:8]);
			rdc("tos upper", `RIB_OFS_TOS_UPPER, {3'h0, wpc[20:16]});
		end
	endtask

	initial begin
		#(100 * 10000);
		fail_count++;
		tally_and_finish();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] r;
		logic e;
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		rst_evt = '0;
		irq_evt = 24'h0;
		hi_prio = 1'b0;
		pc = 21'h000100;
		osc_free = 1'b0;
		pins = 8'hff;
		rows = '{'{capture1_control, 8'h00, 8'hff, 8'h3f}, '{comparator_control, 8'h07, 8'h05, 8'h05},
			'{timer_three_count_high, 8'h00, 8'ha5, 8'ha5}, '{serial1_transmit_buffer, 8'h00, 8'h5a, 8'h5a},
			'{irq_priority_one, 8'hff, 8'h0f, 8'h0f}, '{port_j_direction, 8'hff, 8'h33, 8'h33},
			'{irq_priority_three, 8'h07, 8'hff, 8'h07}, '{oscillator_trim, 8'h00, 8'hff, 8'hdf},
			'{serial1_receive_buffer, 8'h00, 8'hff, 8'h00}};
		cls = '{'{4'h4, 8'hff, 8'h07}, '{4'h2, 8'hff, 8'h01}, '{4'h8, 8'h00, 8'h07}, '{4'hc, 8'h00, 8'h07}};
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		foreach (rows[i]) begin
			rdc("reset value", ra(rows[i].r), rows[i].rv);
			wr(ra(rows[i].r), rows[i].wd);
			rdc("readback", ra(rows[i].r), rows[i].ex);
		end
		chk("cmp pin", {24'h0, cmpc}, 32'h05);
		chk("dir pin", {24'h0, jdir}, 32'h33);
		// reset classes and watchdog wake against retained and cleared registers
		foreach (cls[i]) begin
			wr(ra(timer_three_count_high), 8'hff);
			wr(ra(comparator_control), 8'h01);
			wr(ra(serial1_transmit_buffer), 8'h77);
			wr(ra(irq_priority_one), 8'h0f);
			wr(ra(port_j_direction), 8'h0f);
			pulse(cls[i].e);
			rdc("timer high", ra(timer_three_count_high), cls[i].tmr);
			rdc("comparator", ra(comparator_control), cls[i].cmp);
			if (!cls[i].e.por) rdc("tx buffer", ra(serial1_transmit_buffer), cls[i].e.warm ? 8'h00 : 8'h77);
			rdc("priority one", ra(irq_priority_one), cls[i].e.wake_wdt ? 8'h0f : 8'hff);
			rdc("dir j", ra(port_j_direction), cls[i].e.wake_wdt ? 8'h0f : 8'hff);
			chk("cmp pin", {24'h0, cmpc}, {24'h0, cls[i].cmp});
			chk("dir pin", {24'h0, jdir}, cls[i].e.wake_wdt ? 32'h0f : 32'hff);
		end
		// interrupt wakes: each enable and priority pairing, then fill the stack past full
		wake(8'h80, 1'b1, 1'b1, `RIB_VEC_HI);
		wake(8'h40, 1'b0, 1'b1, `RIB_VEC_LO);
		wake(8'h80, 1'b0, 1'b0, `RIB_VEC_LO);
		wake(8'h40, 1'b1, 1'b0, `RIB_VEC_HI);
		wake(8'h00, 1'b1, 1'b0, `RIB_VEC_HI);
		for (int i = 0; i < 31; i++) begin
			wake(8'hc0, 1'b1, 1'b1, `RIB_VEC_HI);
		end
		pulse(4'h4);
		#1;
		chk("stack cleared", {27'h0, sp}, 32'h0);
		// a flag event at the very edge of a clearing write must survive it
		fork
			wr(ra(irq_flags_one), 8'h00);
			begin
				repeat (3) @(posedge clk);
				irq_evt <= 24'h000002;
				@(posedge clk);
				irq_evt <= 24'h000000;
			end
		join
		rdc("flag beats write", ra(irq_flags_one), 8'h02);
		// port a top bits follow the oscillator mode
		rdc("port a masked", `RIB_OFS_PORT_A, 8'h3f);
		osc_free <= 1'b1;
		rdc("port a free", `RIB_OFS_PORT_A, 8'hff);
		apb(12'h0a8, 1'b0, 32'h0, r, e);
		chk("unmapped err", {31'h0, e}, 32'h1);
		chk("unmapped data", r, 32'h0);
		// second asynchronous reset in mid-run
		wr(ra(comparator_control), 8'h03);
		@(posedge clk);
		nrst <= 1'b0;
		@(posedge clk);
		#1;
		chk("cmp in reset", {24'h0, cmpc}, 32'h07);
		chk("dir in reset", {24'h0, jdir}, 32'hff);
		@(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		rdc("cmp after reset", ra(comparator_control), 8'h07);
		rdc("timer after reset", ra(timer_three_count_high), 8'h00);
		tally_and_finish();
	end
endmodule
